// File: iop_consts.vh
/*
 * Register map constants for the I/O port configuration block.
 * Assumes byte-wide register access on the MCU bus.
 */
`ifndef IOP_CONSTS_VH
`define IOP_CONSTS_VH

// Register index within one port (low address nibble).
`define IOP_REG_DIN   4'h0
`define IOP_REG_DOUT  4'h1
`define IOP_REG_DIR   4'h2
`define IOP_REG_DRV   4'h3
`define IOP_REG_CTRL  4'h4

// Port number (address bits 6:4).
`define IOP_PORT_A    3'h0
`define IOP_PORT_B    3'h1
`define IOP_PORT_C    3'h2
`define IOP_PORT_D    3'h3
`define IOP_PORT_E    3'h4
`define IOP_PORT_F    3'h5
`define IOP_PORT_G    3'h6

// Peripheral mode register address and its enable bit.
`define IOP_ADR_PMODE 8'h80
`define IOP_PMODE_BIT 7

// Reset value of the configuration registers.
`define IOP_CFG_RST   8'h00

`endif

// File: iop_host_model.sv
/* Host microcontroller model: register cycles and its reset line.
   Assumes inputs of the block are sampled on the rising clock edge. */
`timescale 1ns/1ps
module iop_host_model (
   // Clock and answers
   input  wire        i_clk_sys,
   input  wire [7:0]  i_rdata,
   input  wire        i_rvalid,
   input  wire [15:0] i_dbus_out,
   input  wire [15:0] i_dbus_oe,
   // Bus strobes and reset
   output reg         o_sel     = 1'b0,
   output reg         o_wr      = 1'b0,
   output reg         o_rd      = 1'b0,
   output reg  [7:0]  o_addr    = 8'h00,
   output reg  [7:0]  o_wdata   = 8'h00,
   output reg         o_rst_act = 1'b0,
   output reg  [15:0] o_strap_r = 16'h0000
);
   task wr(input [7:0] a, input [7:0] d);
      @(negedge i_clk_sys);
      o_sel = 1'b1;
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(negedge i_clk_sys);
      o_sel = 1'b0;
      o_wr = 1'b0;
      o_wdata = ~d;
   endtask
   task rd(input [7:0] a, output [7:0] q);
      @(negedge i_clk_sys);
      o_sel = 1'b1;
      o_rd = 1'b1;
      o_addr = a;
      @(negedge i_clk_sys);
      o_sel = 1'b0;
      o_rd = 1'b0;
      q = i_rvalid ? i_rdata : 8'hxx;
   endtask
   task rst_on;
      @(negedge i_clk_sys);
      o_rst_act = 1'b1;
   endtask
   // Released data lines read low through the pull-downs.
   task rst_off;
      @(negedge i_clk_sys);
      o_strap_r = i_dbus_out & i_dbus_oe;
      o_rst_act = 1'b0;
   endtask
endmodule

// File: iop_port_config.v
/*
 * I/O port configuration and data logic for seven ports A to G.
 * Assumes all inputs are synchronous to i_clk_sys and that the MCU
 * bus strobes last one clock-enabled cycle per access.
 */
`timescale 1ns/1ps
`include "iop_consts.vh"
module iop_port_config (
   // Clock, reset and enable
   input  wire        i_clk_sys,
   input  wire        i_sys_rst,
   input  wire        i_clk_en,
   // MCU register bus
   input  wire        i_bus_sel,
   input  wire        i_bus_wr,
   input  wire        i_bus_rd,
   input  wire [7:0]  i_bus_addr,
   input  wire [7:0]  i_bus_wdata,
   output reg  [7:0]  o_bus_rdata_r,
   output reg         o_bus_rvalid_r,
   // Data port and reset pattern
   input  wire        i_data_port_mode,
   input  wire        i_rst_pat_en,
   input  wire [15:0] i_rst_pat,
   input  wire        i_mcu_rst_act,
   input  wire        i_bus_busy,
   // Peripheral buffer
   input  wire        i_peripheral_select_0,
   input  wire        i_peripheral_select_1,
   input  wire        i_periph_dir_out,
   input  wire [7:0]  i_periph_wdata,
   output reg  [7:0]  o_periph_rdata_r,
   // JTAG sharing on port E
   input  wire        i_jtag_en,
   input  wire        i_jtag_tdo,
   input  wire        i_jtag_tdo_oe,
   output reg  [2:0]  o_jtag_in_r,
   // Logic output enables and latched address
   input  wire [7:0]  i_pld_oe_a,
   input  wire [7:0]  i_pld_oe_b,
   input  wire [7:0]  i_pld_oe_c,
   input  wire [7:0]  i_pld_oe_f,
   input  wire [15:0] i_addr_latched,
   // Port pins
   input  wire [7:0]  i_pa_in,
   output reg  [7:0]  o_pa_out_r,
   output reg  [7:0]  o_pa_oe_r,
   input  wire [7:0]  i_pb_in,
   output reg  [7:0]  o_pb_out_r,
   output reg  [7:0]  o_pb_oe_r,
   input  wire [7:0]  i_pc_in,
   output reg  [7:0]  o_pc_out_r,
   output reg  [7:0]  o_pc_oe_r,
   input  wire [3:0]  i_pd_in,
   output reg  [3:0]  o_pd_out_r,
   output reg  [3:0]  o_pd_oe_r,
   input  wire [7:0]  i_pe_in,
   output reg  [7:0]  o_pe_out_r,
   output reg  [7:0]  o_pe_oe_r,
   input  wire [7:0]  i_pf_in,
   output reg  [7:0]  o_pf_out_r,
   output reg  [7:0]  o_pf_oe_r,
   input  wire [7:0]  i_pg_in,
   output reg  [7:0]  o_pg_out_r,
   output reg  [7:0]  o_pg_oe_r,
   // Slew controls
   output wire [7:0]  o_pc_fast_slew,
   output wire [7:0]  o_pf_fast_slew
);

   ////////////////////////////////////////////////////////////////////////
   // Pin drive helpers.
   function [7:0] od_oe;
      input [7:0] en;
      input [7:0] od;
      input [7:0] v;
      begin
         od_oe = en & ~(od & v);
      end
   endfunction

   function [7:0] od_val;
      input [7:0] od;
      input [7:0] v;
      begin
         od_val = v & ~od;
      end
   endfunction

   function [7:0] addr_mux;
      input [7:0] ctrl;
      input [7:0] adr;
      input [7:0] dout;
      begin
         addr_mux = (ctrl & adr) | (~ctrl & dout);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus decode.
   reg        pmode_r;
   reg  [7:0] rsel;
   wire [2:0] port   = i_bus_addr[6:4];
   wire [3:0] rg     = i_bus_addr[3:0];
   wire       pwr    = i_bus_sel & i_bus_wr & ~i_bus_addr[7];
   wire [6:0] wr_p   = pwr ? (7'h01 << port) : 7'h00;
   wire [7:0] wdata  = i_data_port_mode ? i_pf_in : i_bus_wdata;
   wire       psel   = i_peripheral_select_0 | i_peripheral_select_1;
   wire       rpat   = i_rst_pat_en & i_mcu_rst_act & ~i_bus_busy;

   wire [7:0] rd_a;
   wire [7:0] en_a;
   wire [7:0] drv_a;
   wire [7:0] do_a;

   wire [7:0] rd_b;
   wire [7:0] en_b;
   wire [7:0] drv_b;
   wire [7:0] do_b;

   wire [7:0] rd_c;
   wire [7:0] en_c;
   wire [7:0] drv_c;
   wire [7:0] do_c;

   wire [7:0] rd_d;
   wire [7:0] en_d;
   wire [7:0] drv_d;
   wire [7:0] do_d;

   wire [7:0] rd_e;
   wire [7:0] en_e;
   wire [7:0] drv_e;
   wire [7:0] do_e;
   wire [7:0] ct_e;

   wire [7:0] rd_f;
   wire [7:0] en_f;
   wire [7:0] drv_f;
   wire [7:0] do_f;
   wire [7:0] ct_f;

   wire [7:0] rd_g;
   wire [7:0] en_g;
   wire [7:0] drv_g;
   wire [7:0] do_g;
   wire [7:0] ct_g;

   ////////////////////////////////////////////////////////////////////////
   // Port register slices.
   iop_port_slice #(.W(8), .HAS_CTRL(0)) u_pa (
      .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
      .i_wr(wr_p[0]), .i_reg(rg), .i_wdata(wdata), .o_rdata(rd_a),
      .i_pin_in(i_pa_in), .i_pld_oe(i_pld_oe_a), .o_en(en_a),
      .o_ctrl(), .o_drv(drv_a), .o_dout(do_a));

   iop_port_slice #(.W(8), .HAS_CTRL(0)) u_pb (
      .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
      .i_wr(wr_p[1]), .i_reg(rg), .i_wdata(wdata), .o_rdata(rd_b),
      .i_pin_in(i_pb_in), .i_pld_oe(i_pld_oe_b), .o_en(en_b),
      .o_ctrl(), .o_drv(drv_b), .o_dout(do_b));

   iop_port_slice #(.W(8), .HAS_CTRL(0)) u_pc (
      .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
      .i_wr(wr_p[2]), .i_reg(rg), .i_wdata(wdata), .o_rdata(rd_c),
      .i_pin_in(i_pc_in), .i_pld_oe(i_pld_oe_c), .o_en(en_c),
      .o_ctrl(), .o_drv(drv_c), .o_dout(do_c));

   iop_port_slice #(.W(4), .HAS_CTRL(0)) u_pd (
      .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
      .i_wr(wr_p[3]), .i_reg(rg), .i_wdata(wdata), .o_rdata(rd_d),
      .i_pin_in({4'h0, i_pd_in}), .i_pld_oe(8'h00), .o_en(en_d),
      .o_ctrl(), .o_drv(drv_d), .o_dout(do_d));

   iop_port_slice #(.W(8), .HAS_CTRL(1)) u_pe (
      .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
      .i_wr(wr_p[4]), .i_reg(rg), .i_wdata(wdata), .o_rdata(rd_e),
      .i_pin_in(i_pe_in), .i_pld_oe(8'h00), .o_en(en_e),
      .o_ctrl(ct_e), .o_drv(drv_e), .o_dout(do_e));

   iop_port_slice #(.W(8), .HAS_CTRL(1)) u_pf (
      .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
      .i_wr(wr_p[5]), .i_reg(rg), .i_wdata(wdata), .o_rdata(rd_f),
      .i_pin_in(i_pf_in), .i_pld_oe(i_pld_oe_f), .o_en(en_f),
      .o_ctrl(ct_f), .o_drv(drv_f), .o_dout(do_f));

   iop_port_slice #(.W(8), .HAS_CTRL(1)) u_pg (
      .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
      .i_wr(wr_p[6]), .i_reg(rg), .i_wdata(wdata), .o_rdata(rd_g),
      .i_pin_in(i_pg_in), .i_pld_oe(8'h00), .o_en(en_g),
      .o_ctrl(ct_g), .o_drv(drv_g), .o_dout(do_g));

   assign o_pc_fast_slew = drv_c;
   assign o_pf_fast_slew = drv_f;

   ////////////////////////////////////////////////////////////////////////
   // Read data select.
   always @* begin
      rsel = 8'h00;
      if (i_bus_addr == `IOP_ADR_PMODE) begin
         rsel[`IOP_PMODE_BIT] = pmode_r;
      end else if (!i_bus_addr[7]) begin
         case (port)
            `IOP_PORT_A: rsel = rd_a;
            `IOP_PORT_B: rsel = rd_b;
            `IOP_PORT_C: rsel = rd_c;
            `IOP_PORT_D: rsel = rd_d;
            `IOP_PORT_E: rsel = rd_e;
            `IOP_PORT_F: rsel = rd_f;
            `IOP_PORT_G: rsel = rd_g;
            default:     rsel = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next pin drive for every port.
   reg [7:0] pa_o_nxt;
   reg [7:0] pa_oe_nxt;
   reg [7:0] pb_o_nxt;
   reg [7:0] pb_oe_nxt;
   reg [7:0] pc_o_nxt;
   reg [7:0] pc_oe_nxt;
   reg [7:0] pd_o_nxt;
   reg [7:0] pd_oe_nxt;
   reg [7:0] pe_o_nxt;
   reg [7:0] pe_oe_nxt;
   reg [7:0] pf_o_nxt;
   reg [7:0] pf_oe_nxt;
   reg [7:0] pg_o_nxt;
   reg [7:0] pg_oe_nxt;

   reg [7:0] ve;
   reg [7:0] vf;
   reg [7:0] vg;

   always @* begin
      pa_o_nxt  = od_val(drv_a, do_a);
      pa_oe_nxt = od_oe(en_a, drv_a, do_a);
      pb_o_nxt  = od_val(drv_b, do_b);
      pb_oe_nxt = od_oe(en_b, drv_b, do_b);
      pc_o_nxt  = do_c;
      pc_oe_nxt = en_c;
      pd_o_nxt  = od_val(drv_d, do_d);
      pd_oe_nxt = od_oe(en_d, drv_d, do_d);
      ve = addr_mux(ct_e, i_addr_latched[7:0], do_e);
      vf = addr_mux(ct_f, i_addr_latched[7:0], do_f);
      vg = addr_mux(ct_g, i_addr_latched[15:8], do_g);
      pe_o_nxt  = od_val(drv_e, ve);
      pe_oe_nxt = od_oe(en_e, drv_e, ve);
      pf_o_nxt  = vf;
      pf_oe_nxt = en_f;
      pg_o_nxt  = od_val(drv_g, vg);
      pg_oe_nxt = od_oe(en_g, drv_g, vg);
      if (i_jtag_en) begin
         pe_o_nxt[3:0]  = {i_jtag_tdo, 3'b000};
         pe_oe_nxt[3:0] = {i_jtag_tdo_oe, 3'b000};
      end
      if (rpat) begin
         pf_o_nxt  = i_rst_pat[7:0];
         pf_oe_nxt = 8'hff;
         pg_o_nxt  = i_rst_pat[15:8];
         pg_oe_nxt = 8'hff;
      end else if (i_data_port_mode) begin
         pf_o_nxt  = o_bus_rdata_r;
         pf_oe_nxt = {8{o_bus_rvalid_r}};
         pg_o_nxt  = 8'h00;
         pg_oe_nxt = {8{o_bus_rvalid_r}};
      end else if (pmode_r) begin
         pf_o_nxt  = i_periph_wdata;
         pf_oe_nxt = {8{psel & i_periph_dir_out}};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs and peripheral mode register.
   always @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         pmode_r          <= 1'b0;
         o_bus_rdata_r    <= 8'h00;
         o_bus_rvalid_r   <= 1'b0;
         o_periph_rdata_r <= 8'h00;
         o_jtag_in_r      <= 3'b000;
         o_pa_out_r <= 8'h00;
         o_pa_oe_r  <= 8'h00;
         o_pb_out_r <= 8'h00;
         o_pb_oe_r  <= 8'h00;
         o_pc_out_r <= 8'h00;
         o_pc_oe_r  <= 8'h00;
         o_pd_out_r <= 4'h0;
         o_pd_oe_r  <= 4'h0;
         o_pe_out_r <= 8'h00;
         o_pe_oe_r  <= 8'h00;
         o_pf_out_r <= 8'h00;
         o_pf_oe_r  <= 8'h00;
         o_pg_out_r <= 8'h00;
         o_pg_oe_r  <= 8'h00;
      end else if (i_clk_en) begin
         if (i_bus_sel && i_bus_wr && i_bus_addr == `IOP_ADR_PMODE) begin
            pmode_r <= wdata[`IOP_PMODE_BIT];
         end
         o_bus_rvalid_r <= i_bus_sel & i_bus_rd;
         if (i_bus_sel && i_bus_rd) begin
            o_bus_rdata_r <= rsel;
         end
         if (pmode_r && psel && !i_periph_dir_out) begin
            o_periph_rdata_r <= i_pf_in;
         end
         o_jtag_in_r <= i_jtag_en ? i_pe_in[2:0] : 3'b000;
         o_pa_out_r <= pa_o_nxt;
         o_pa_oe_r  <= pa_oe_nxt;
         o_pb_out_r <= pb_o_nxt;
         o_pb_oe_r  <= pb_oe_nxt;
         o_pc_out_r <= pc_o_nxt;
         o_pc_oe_r  <= pc_oe_nxt;
         o_pd_out_r <= pd_o_nxt[3:0];
         o_pd_oe_r  <= pd_oe_nxt[3:0];
         o_pe_out_r <= pe_o_nxt;
         o_pe_oe_r  <= pe_oe_nxt;
         o_pf_out_r <= pf_o_nxt;
         o_pf_oe_r  <= pf_oe_nxt;
         o_pg_out_r <= pg_o_nxt;
         o_pg_oe_r  <= pg_oe_nxt;
      end
   end

endmodule

// File: iop_port_config_checker.sv
/* Assertions on the I/O port configuration block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module iop_chk (
   // Clock and control
   input wire        i_clk_sys,
   input wire        i_sys_rst,
   input wire        i_clk_en,
   // Bus and modes
   input wire        i_bus_sel,
   input wire        i_bus_wr,
   input wire        i_bus_rd,
   input wire [7:0]  i_bus_addr,
   input wire [7:0]  i_bus_wdata,
   input wire        o_bus_rvalid_r,
   input wire        i_data_port_mode,
   input wire        i_rst_pat_en,
   input wire [15:0] i_rst_pat,
   input wire        i_mcu_rst_act,
   input wire        i_bus_busy,
   input wire        i_peripheral_select_0,
   input wire        i_peripheral_select_1,
   input wire        i_jtag_en,
   // Pins
   input wire [7:0]  i_pld_oe_c,
   input wire [7:0]  i_pe_in,
   input wire [7:0]  i_pf_in,
   input wire [2:0]  o_jtag_in_r,
   input wire [7:0]  o_pa_oe_r,
   input wire [7:0]  o_pc_oe_r,
   input wire [7:0]  o_pf_oe_r,
   input wire [7:0]  o_pf_out_r,
   input wire [7:0]  o_pg_oe_r,
   input wire [7:0]  o_pg_out_r,
   input wire [7:0]  o_pc_fast_slew,
   input wire [7:0]  o_pf_fast_slew
);
   reg  pmode_r;
   wire rd_take = i_clk_en & i_bus_sel & i_bus_rd;
   wire pat_act = i_rst_pat_en & i_mcu_rst_act & ~i_bus_busy;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   always @(posedge i_clk_sys) begin
      if (i_sys_rst)
         pmode_r <= 1'b0;
      else if (i_clk_en & i_bus_sel & i_bus_wr & (i_bus_addr == 8'h80))
         pmode_r <= i_data_port_mode ? i_pf_in[7] : i_bus_wdata[7];
   end
   sequence s_read_taken;
      rd_take;
   endsequence
   sequence s_pat_drive;
      i_clk_en & pat_act;
   endsequence
   a_read_answer: assert property (s_read_taken |=> o_bus_rvalid_r)
      else $error("read answer missing");
   a_no_spurious: assert property (o_bus_rvalid_r |-> $past(rd_take))
      else $error("answer without read");
   a_pattern_drive: assert property (s_pat_drive |=> o_pf_oe_r == 8'hff
      && o_pg_oe_r == 8'hff && {o_pg_out_r, o_pf_out_r} == $past(i_rst_pat))
      else $error("reset pattern not driven");
   a_dp_release: assert property (i_clk_en & i_data_port_mode & ~pat_act
      & ~o_bus_rvalid_r & ~rd_take |=> o_pf_oe_r == 8'h00 && o_pg_oe_r == 8'h00)
      else $error("data port driven while idle");
   a_periph_float: assert property (i_clk_en & pmode_r & ~pat_act
      & ~i_peripheral_select_0 & ~i_peripheral_select_1 & ~i_data_port_mode
      |=> o_pf_oe_r == 8'h00) else $error("peripheral buffer not floating");
   a_logic_oe: assert property (i_clk_en
      |=> (o_pc_oe_r & $past(i_pld_oe_c)) == $past(i_pld_oe_c))
      else $error("logic enable did not drive");
   a_jtag_input: assert property (i_clk_en |=> o_jtag_in_r ==
      ($past(i_jtag_en) ? $past(i_pe_in[2:0]) : 3'h0))
      else $error("scan inputs wrong");
   a_reset_clears: assert property (disable iff (1'b0)
      i_sys_rst & i_clk_en |=> {o_pa_oe_r, o_pf_oe_r, o_pc_fast_slew,
      o_pf_fast_slew, o_bus_rvalid_r} == 33'h0)
      else $error("reset did not clear");
endmodule
bind iop_port_config iop_chk chk_u (.i_clk_sys, .i_sys_rst, .i_clk_en,
   .i_bus_sel, .i_bus_wr, .i_bus_rd, .i_bus_addr, .i_bus_wdata,
   .o_bus_rvalid_r, .i_data_port_mode, .i_rst_pat_en, .i_rst_pat,
   .i_mcu_rst_act, .i_bus_busy, .i_peripheral_select_0,
   .i_peripheral_select_1, .i_jtag_en, .i_pld_oe_c, .i_pe_in, .i_pf_in,
   .o_jtag_in_r, .o_pa_oe_r, .o_pc_oe_r, .o_pf_oe_r, .o_pf_out_r,
   .o_pg_oe_r, .o_pg_out_r, .o_pc_fast_slew, .o_pf_fast_slew);

// File: iop_port_slice.v
/*
 * One port's configuration and data registers with readback.
 * Assumes the parent decodes the port and supplies one write strobe.
 */
`timescale 1ns/1ps
`include "iop_consts.vh"
module iop_port_slice #(
   parameter W        = 8,
   parameter HAS_CTRL = 0
) (
   // Clock and reset
   input  wire       i_clk_sys,
   input  wire       i_sys_rst,
   input  wire       i_clk_en,
   // Register access
   input  wire       i_wr,
   input  wire [3:0] i_reg,
   input  wire [7:0] i_wdata,
   output reg  [7:0] o_rdata,
   // Pin side
   input  wire [7:0] i_pin_in,
   input  wire [7:0] i_pld_oe,
   output wire [7:0] o_en,
   output wire [7:0] o_ctrl,
   output wire [7:0] o_drv,
   output wire [7:0] o_dout
);

   localparam [7:0] MASK = 8'hff >> (8 - W);

   reg [7:0] dir_r;
   reg [7:0] drv_r;
   reg [7:0] ctrl_r;
   reg [7:0] dout_r;
   reg [7:0] din_r;

   ////////////////////////////////////////////////////////////////////////
   // Registers.
   always @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         dir_r  <= `IOP_CFG_RST;
         drv_r  <= `IOP_CFG_RST;
         ctrl_r <= `IOP_CFG_RST;
         dout_r <= 8'h00;
         din_r  <= 8'h00;
      end else if (i_clk_en) begin
         din_r <= i_pin_in & MASK;
         if (i_wr) begin
            case (i_reg)
               `IOP_REG_DOUT: dout_r <= i_wdata & MASK;
               `IOP_REG_DIR:  dir_r  <= i_wdata & MASK;
               `IOP_REG_DRV:  drv_r  <= i_wdata & MASK;
               `IOP_REG_CTRL: begin
                  if (HAS_CTRL != 0) begin
                     ctrl_r <= i_wdata;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Readback.
   always @* begin
      case (i_reg)
         `IOP_REG_DIN:  o_rdata = din_r;
         `IOP_REG_DOUT: o_rdata = dout_r;
         `IOP_REG_DIR:  o_rdata = dir_r;
         `IOP_REG_DRV:  o_rdata = drv_r;
         `IOP_REG_CTRL: o_rdata = ctrl_r;
         default:       o_rdata = 8'h00;
      endcase
   end

   assign o_en   = (dir_r | i_pld_oe) & MASK;
   assign o_ctrl = ctrl_r;
   assign o_drv  = drv_r;
   assign o_dout = dout_r;

endmodule

// File: tb.sv
/* Self-checking bench for the I/O port configuration block.
   Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/1ps
module tb;
   logic       i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_clk_en = 1'b1;
   logic       i_data_port_mode = 0, i_rst_pat_en = 0, i_bus_busy = 0;
   logic       i_peripheral_select_0 = 0, i_peripheral_select_1 = 0;
   logic       i_periph_dir_out = 0, i_jtag_en = 0;
   logic       i_jtag_tdo = 0, i_jtag_tdo_oe = 0;
   logic [15:0] i_rst_pat = 0, i_addr_latched = 0;
   logic [7:0] i_periph_wdata = 0, i_pld_oe_a = 0, i_pld_oe_b = 0;
   logic [7:0] i_pld_oe_c = 0, i_pld_oe_f = 0, i_pa_in = 0, i_pb_in = 0;
   logic [7:0] i_pc_in = 0, i_pe_in = 0, i_pf_in = 0, i_pg_in = 0;
   logic [3:0] i_pd_in = 0;
   wire        i_bus_sel, i_bus_wr, i_bus_rd, i_mcu_rst_act, o_bus_rvalid_r;
   wire [7:0]  i_bus_addr, i_bus_wdata, o_bus_rdata_r, o_periph_rdata_r;
   wire [7:0]  o_pa_out_r, o_pa_oe_r, o_pb_out_r, o_pb_oe_r, o_pc_out_r;
   wire [7:0]  o_pc_oe_r, o_pe_out_r, o_pe_oe_r, o_pf_out_r, o_pf_oe_r;
   wire [7:0]  o_pg_out_r, o_pg_oe_r, o_pc_fast_slew, o_pf_fast_slew;
   wire [3:0]  o_pd_out_r, o_pd_oe_r;
   wire [2:0]  o_jtag_in_r;
   wire [15:0] strap;
   int         errors = 0, tests_run = 0, cyc = 0;
   logic [23:0] rows [0:9] = '{24'h02a5a5, 24'h133c3c, 24'h245500,
      24'h32ff0f, 24'h33ff0f, 24'h448181, 24'h547e7e, 24'h61c3c3,
      24'h80ff80, 24'h751200};
   iop_port_config dut_u (.i_clk_sys, .i_sys_rst, .i_clk_en, .i_bus_sel,
      .i_bus_wr, .i_bus_rd, .i_bus_addr, .i_bus_wdata, .o_bus_rdata_r,
      .o_bus_rvalid_r, .i_data_port_mode, .i_rst_pat_en, .i_rst_pat,
      .i_mcu_rst_act, .i_bus_busy, .i_peripheral_select_0,
      .i_peripheral_select_1, .i_periph_dir_out, .i_periph_wdata,
      .o_periph_rdata_r, .i_jtag_en, .i_jtag_tdo, .i_jtag_tdo_oe,
      .o_jtag_in_r, .i_pld_oe_a, .i_pld_oe_b, .i_pld_oe_c, .i_pld_oe_f,
      .i_addr_latched, .i_pa_in, .o_pa_out_r, .o_pa_oe_r, .i_pb_in,
      .o_pb_out_r, .o_pb_oe_r, .i_pc_in, .o_pc_out_r, .o_pc_oe_r, .i_pd_in,
      .o_pd_out_r, .o_pd_oe_r, .i_pe_in, .o_pe_out_r, .o_pe_oe_r, .i_pf_in,
      .o_pf_out_r, .o_pf_oe_r, .i_pg_in, .o_pg_out_r, .o_pg_oe_r,
      .o_pc_fast_slew, .o_pf_fast_slew);
   iop_host_model host_u (.i_clk_sys, .i_rdata(o_bus_rdata_r),
      .i_rvalid(o_bus_rvalid_r), .i_dbus_out({o_pg_out_r, o_pf_out_r}),
      .i_dbus_oe({o_pg_oe_r, o_pf_oe_r}), .o_sel(i_bus_sel),
      .o_wr(i_bus_wr), .o_rd(i_bus_rd), .o_addr(i_bus_addr),
      .o_wdata(i_bus_wdata), .o_rst_act(i_mcu_rst_act), .o_strap_r(strap));
   always #5 i_clk_sys = ~i_clk_sys;
   ////////////////////////////////////////////////////////////////////////
   task give_verdict;
      $display("tests_run %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         give_verdict;
      end
   end
   task chk(input [15:0] got, input [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task rdc(input [7:0] a, input [7:0] exp);
      logic [7:0] q;
      host_u.rd(a, q);
      chk({8'h00, q}, {8'h00, exp});
   endtask
   task tick(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   task do_reset;
      @(negedge i_clk_sys);
      i_sys_rst = 1'b1;
      tick(10);
      i_sys_rst = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset;
      for (int i = 0; i < 10; i++) begin
         host_u.wr(rows[i][23:16], rows[i][15:8]);
         rdc(rows[i][23:16], rows[i][7:0]);
      end
      do_reset;
      for (int i = 0; i < 10; i++)
         rdc(rows[i][23:16], 8'h00);
      host_u.wr(8'h02, 8'h07);
      host_u.wr(8'h01, 8'ha5);
      tick(2);
      chk({8'h00, o_pa_oe_r}, 16'h0007);
      chk({8'h00, o_pa_out_r & o_pa_oe_r}, 16'h0005);
      host_u.wr(8'h03, 8'hff);
      host_u.wr(8'h02, 8'hff);
      tick(2);
      chk({o_pa_oe_r, o_pa_out_r}, 16'h5a00);
      host_u.wr(8'h32, 8'hff);
      host_u.wr(8'h33, 8'h03);
      host_u.wr(8'h31, 8'h0a);
      tick(2);
      chk({8'h00, o_pd_oe_r, o_pd_out_r}, 16'h00d8);
      i_pld_oe_c = 8'h30;
      host_u.wr(8'h22, 8'h01);
      host_u.wr(8'h23, 8'h81);
      host_u.wr(8'h21, 8'h3c);
      tick(2);
      chk({8'h00, o_pc_oe_r}, 16'h0031);
      chk({8'h00, o_pc_fast_slew}, 16'h0081);
      chk({8'h00, o_pc_out_r}, 16'h003c);
      i_pb_in = 8'h3c;
      host_u.wr(8'h12, 8'hff);
      rdc(8'h10, 8'h3c);
      i_pld_oe_f = 8'h0f;
      host_u.wr(8'h11, 8'h69);
      host_u.wr(8'h51, 8'h96);
      host_u.wr(8'h53, 8'h42);
      tick(2);
      chk({o_pb_oe_r, o_pb_out_r}, 16'hff69);
      chk({o_pf_oe_r, o_pf_out_r}, 16'h0f96);
      chk({8'h00, o_pf_fast_slew}, 16'h0042);
      i_pld_oe_f = 8'h00;
      i_addr_latched = 16'h12c4;
      host_u.wr(8'h44, 8'hff);
      host_u.wr(8'h42, 8'hff);
      host_u.wr(8'h64, 8'hff);
      host_u.wr(8'h62, 8'hff);
      tick(2);
      chk({o_pe_out_r, o_pg_out_r}, 16'hc412);
      i_jtag_en = 1'b1;
      i_pe_in = 8'h05;
      i_jtag_tdo = 1'b1;
      i_jtag_tdo_oe = 1'b1;
      tick(2);
      chk({13'h0000, o_jtag_in_r}, 16'h0005);
      chk({11'h000, o_pe_oe_r[3:0], o_pe_out_r[3]}, 16'h0011);
      i_jtag_en = 1'b0;
      host_u.wr(8'h80, 8'h80);
      i_peripheral_select_0 = 1'b1;
      i_periph_dir_out = 1'b1;
      i_periph_wdata = 8'h5a;
      tick(2);
      chk({o_pf_oe_r, o_pf_out_r}, 16'hff5a);
      i_peripheral_select_0 = 1'b0;
      tick(2);
      chk({8'h00, o_pf_oe_r}, 16'h0000);
      i_peripheral_select_1 = 1'b1;
      i_periph_dir_out = 1'b0;
      i_pf_in = 8'hc3;
      tick(2);
      chk({8'h00, o_periph_rdata_r}, 16'h00c3);
      host_u.wr(8'h80, 8'h00);
      i_periph_dir_out = 1'b1;
      tick(2);
      chk({8'h00, o_pf_oe_r}, 16'h0000);
      i_peripheral_select_1 = 1'b0;
      i_clk_en = 1'b0;
      host_u.wr(8'h02, 8'h00);
      i_clk_en = 1'b1;
      rdc(8'h02, 8'hff);
      i_data_port_mode = 1'b1;
      i_rst_pat_en = 1'b1;
      i_rst_pat = 16'hbeef;
      host_u.rst_on;
      tick(2);
      chk({o_pg_oe_r, o_pf_oe_r}, 16'hffff);
      chk({o_pg_out_r, o_pf_out_r}, 16'hbeef);
      i_bus_busy = 1'b1;
      tick(2);
      chk({o_pg_oe_r, o_pf_oe_r}, 16'h0000);
      i_bus_busy = 1'b0;
      tick(2);
      host_u.rst_off;
      chk(strap, 16'hbeef);
      tick(2);
      chk({o_pg_oe_r, o_pf_oe_r}, 16'h0000);
      i_pf_in = 8'h3c;
      host_u.wr(8'h02, 8'h00);
      rdc(8'h02, 8'h3c);
      give_verdict;
   end
endmodule
